// [pkg/fblp_pkg.sv]
// Constants and types of the flash boot-lock protection block
package fblp_pkg;
    // Register byte offsets
    localparam logic [3:0] FBLP_REG_EXT_OFS = 4'h0;
    localparam logic [3:0] FBLP_REG_LOCK_OFS = 4'h4;
    localparam logic [3:0] FBLP_REG_STAT_OFS = 4'h8;
    // Lock register field positions, bit value 0 means programmed
    localparam int FBLP_GLB_LSB = 0;
    localparam int FBLP_APP_LSB = 2;
    localparam int FBLP_BOOT_LSB = 4;
    // Status register field positions
    localparam int FBLP_STAT_BUSY = 0;
    localparam int FBLP_STAT_DENIED = 1;
    localparam int FBLP_STAT_FUSE = 2;
    localparam int FBLP_STAT_IRQSUP = 3;
    // Values after reset
    localparam logic [5:0] FBLP_LOCK_RST = 6'h3f;
    localparam logic [7:0] FBLP_EXT_RST = 8'h00;
    localparam logic [22:0] FBLP_APP_RESET_WORD = 23'h000000;
    // Lock pair encodings as {hi, lo}
    localparam logic [1:0] FBLP_MODE_FREE = 2'h3;
    localparam logic [1:0] FBLP_MODE_NOWR = 2'h2;
    localparam logic [1:0] FBLP_MODE_NORW = 2'h0;
    localparam logic [1:0] FBLP_MODE_NORD = 2'h1;
    // Time the latched address is held for a programming operation
    localparam int FBLP_PROG_HOLD_NS = 40;
    localparam int FBLP_CLK_PERIOD_NS = 10;
    localparam logic [7:0] FBLP_PROG_CYCLES =
        8'((FBLP_PROG_HOLD_NS + FBLP_CLK_PERIOD_NS - 1) / FBLP_CLK_PERIOD_NS);
    typedef enum logic [0:0] {
        FBLP_IDLE = 1'b0,
        FBLP_PROG = 1'b1
    } fblp_state_t;
endpackage

// [core/fblp_core.sv]
// Flash boot-lock protection, self-programming address and register slave
`timescale 1ns/1ns
// Overview of operation
// - Lock bits only get programmed by software or serial pins; only chip erase and system reset clear.
// - Global write-lock mode blocks every store-program write.
// - Global read/write-lock mode blocks loads and store-program writes.
// - Application lock pair both unprogrammed: no application section restriction.
// - Application modes 2 and 3 block store-program writes to application section.
// - Application modes 3 and 4 block loads from boot code into application.
// - Application modes 3 and 4 suppress interrupts in application when vectors boot-side.
// - Boot loader lock pair both unprogrammed: no boot section restriction.
// - Boot modes 2 and 3 block store-program writes to boot loader section.
// - Boot modes 3 and 4 block loads from application code into boot section.
// - Boot modes 3 and 4 suppress interrupts in boot when vectors application-side.
// - Reset fuse unprogrammed gives word 0; programmed gives boot loader start.
// - Running program can never alter a fuse; only programming pins do.
// - Address is extension byte above high and low pointer bytes, bits 23..0.
// - Low word bits address word in page, high bits address the page.
// - Target address latched at operation start; pointer changes then ignored.
// - Loads address bytes, byte select bit choosing low or high byte.
// - Store-program from application section is denied; only boot code programs.
module fblp_core #(
    parameter int PAGE_WORD_BITS = 7,
    parameter logic [22:0] BOOT_START_WORD = 23'h00f000,
    parameter bit HAS_EXT = 1'b1
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CPU_REQ,
    input wire logic CPU_STORE,
    input wire logic [22:0] CPU_PC,
    input wire logic [7:0] CPU_PTR_HI,
    input wire logic [7:0] CPU_PTR_LO,
    input wire logic CPU_IVEC_BOOT,
    output logic CPU_BUSY,
    output logic CPU_DENY,
    output logic IRQ_SUPPRESS,
    output logic [22:0] RESET_VECTOR,
    input wire logic FUSE_BOOT_RESET,
    input wire logic CHIP_ERASE,
    input wire logic SER_LOCK_STROBE,
    input wire logic [5:0] SER_LOCK_DATA,
    output logic FLASH_WR,
    output logic FLASH_RD,
    output logic [22-PAGE_WORD_BITS:0] FLASH_PAGE,
    output logic [PAGE_WORD_BITS-1:0] FLASH_WORD,
    output logic FLASH_BYTE_SEL
);
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    logic strobe_prev_q;
    logic fuse_s;
    logic erase_s;
    logic ser_prog;
    logic [7:0] ext_q;
    logic [5:0] lock_q;
    logic [1:0] glb_lk;
    logic [1:0] app_lk;
    logic [1:0] boot_lk;
    fblp_pkg::fblp_state_t state_q;
    logic [7:0] cnt_q;
    logic [23:0] addr_q;
    logic [23:0] ptr;
    logic exec_boot;
    logic tgt_boot;
    logic access_ok;
    logic accept;
    logic bus_req;
    logic bus_done;

    function automatic logic in_boot(input logic [22:0] word);
        in_boot = (word >= BOOT_START_WORD);
    endfunction

    // Pins from the programming side cross into the core clock
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
            strobe_prev_q <= 1'b0;
        end else begin
            sync1_q <= {FUSE_BOOT_RESET, CHIP_ERASE, SER_LOCK_STROBE, SER_LOCK_DATA};
            sync2_q <= sync1_q;
            strobe_prev_q <= sync2_q[6];
        end
    end
    // Data pins settle before the strobe, so sampling them at its edge is safe
    assign fuse_s = sync2_q[8];
    assign erase_s = sync2_q[7];
    assign ser_prog = sync2_q[6] & ~strobe_prev_q;

    assign glb_lk = lock_q[fblp_pkg::FBLP_GLB_LSB +: 2];
    assign app_lk = lock_q[fblp_pkg::FBLP_APP_LSB +: 2];
    assign boot_lk = lock_q[fblp_pkg::FBLP_BOOT_LSB +: 2];
    assign ptr = {(HAS_EXT ? ext_q : 8'h00), CPU_PTR_HI, CPU_PTR_LO};
    assign exec_boot = in_boot(CPU_PC);
    assign tgt_boot = in_boot(ptr[23:1]);

    // Protection check from executing section, target section and locks
    always_comb begin
        access_ok = 1'b1;
        if (CPU_STORE) begin
            if (!exec_boot)
                access_ok = 1'b0;
            if (glb_lk == fblp_pkg::FBLP_MODE_NOWR || glb_lk == fblp_pkg::FBLP_MODE_NORW)
                access_ok = 1'b0;
            if (!tgt_boot && !app_lk[0])
                access_ok = 1'b0;
            if (tgt_boot && !boot_lk[0])
                access_ok = 1'b0;
        end else begin
            if (glb_lk == fblp_pkg::FBLP_MODE_NORW)
                access_ok = 1'b0;
            if (exec_boot && !tgt_boot && !app_lk[1])
                access_ok = 1'b0;
            if (!exec_boot && tgt_boot && !boot_lk[1])
                access_ok = 1'b0;
        end
    end

    assign accept = CPU_REQ && state_q == fblp_pkg::FBLP_IDLE;

    // Access sequencer; requests while busy are ignored
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_q <= fblp_pkg::FBLP_IDLE;
            cnt_q <= 8'h00;
            CPU_BUSY <= 1'b0;
            CPU_DENY <= 1'b0;
            FLASH_WR <= 1'b0;
            FLASH_RD <= 1'b0;
        end else begin
            FLASH_WR <= accept && CPU_STORE && access_ok;
            FLASH_RD <= accept && !CPU_STORE && access_ok;
            CPU_DENY <= accept && !access_ok;
            case (state_q)
                fblp_pkg::FBLP_IDLE: begin
                    if (accept && CPU_STORE && access_ok) begin
                        state_q <= fblp_pkg::FBLP_PROG;
                        cnt_q <= fblp_pkg::FBLP_PROG_CYCLES;
                        CPU_BUSY <= 1'b1;
                    end
                end
                fblp_pkg::FBLP_PROG: begin
                    cnt_q <= cnt_q - 8'h01;
                    if (cnt_q == 8'h01) begin
                        state_q <= fblp_pkg::FBLP_IDLE;
                        CPU_BUSY <= 1'b0;
                    end
                end
                default: begin
                    state_q <= fblp_pkg::FBLP_IDLE;
                    CPU_BUSY <= 1'b0;
                end
            endcase
        end
    end

    // Address taken only when an accepted access passes the protection check
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST)
            addr_q <= 24'h000000;
        else if (accept && access_ok)
            addr_q <= ptr;
    end
    assign FLASH_PAGE = addr_q[23:PAGE_WORD_BITS+1];
    assign FLASH_WORD = addr_q[PAGE_WORD_BITS:1];
    assign FLASH_BYTE_SEL = addr_q[0];

    // Interrupt gating and reset vector
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            IRQ_SUPPRESS <= 1'b0;
            RESET_VECTOR <= fblp_pkg::FBLP_APP_RESET_WORD;
        end else begin
            IRQ_SUPPRESS <= (!exec_boot && CPU_IVEC_BOOT && !app_lk[1])
                || (exec_boot && !CPU_IVEC_BOOT && !boot_lk[1]);
            // Fuse has no write path from the bus side at all
            RESET_VECTOR <= fuse_s ? fblp_pkg::FBLP_APP_RESET_WORD : BOOT_START_WORD;
        end
    end

    // Avalon slave: one wait cycle, then a single-cycle answer
    assign bus_req = AVS_READ || AVS_WRITE;
    assign bus_done = bus_req && !AVS_WAITREQUEST;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else begin
            AVS_WAITREQUEST <= !(bus_req && AVS_WAITREQUEST);
            if (AVS_READ && AVS_WAITREQUEST) begin
                case (AVS_ADDRESS)
                    fblp_pkg::FBLP_REG_EXT_OFS: AVS_READDATA <= {24'h000000, ext_q};
                    fblp_pkg::FBLP_REG_LOCK_OFS: AVS_READDATA <= {26'h0000000, lock_q};
                    fblp_pkg::FBLP_REG_STAT_OFS: begin
                        AVS_READDATA <= 32'h00000000;
                        AVS_READDATA[fblp_pkg::FBLP_STAT_BUSY] <= CPU_BUSY;
                        AVS_READDATA[fblp_pkg::FBLP_STAT_DENIED] <= CPU_DENY;
                        AVS_READDATA[fblp_pkg::FBLP_STAT_FUSE] <= fuse_s;
                        AVS_READDATA[fblp_pkg::FBLP_STAT_IRQSUP] <= IRQ_SUPPRESS;
                    end
                    default: AVS_READDATA <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST)
            ext_q <= fblp_pkg::FBLP_EXT_RST;
        else if (HAS_EXT && bus_done && AVS_WRITE && AVS_BYTEENABLE[0]
                 && AVS_ADDRESS == fblp_pkg::FBLP_REG_EXT_OFS)
            ext_q <= AVS_WRITEDATA[7:0];
    end

    // Writes can only program bits; erase and system reset are the only ways back to 1
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST)
            lock_q <= fblp_pkg::FBLP_LOCK_RST;
        else if (erase_s)
            lock_q <= fblp_pkg::FBLP_LOCK_RST;
        else if (bus_done && AVS_WRITE && AVS_BYTEENABLE[0]
                 && AVS_ADDRESS == fblp_pkg::FBLP_REG_LOCK_OFS)
            lock_q <= lock_q & AVS_WRITEDATA[5:0];
        else if (ser_prog)
            lock_q <= lock_q & sync2_q[5:0];
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    glb_wrlock_a: assert property ((accept && CPU_STORE && glb_lk == 2'h2) |=>
        (CPU_DENY && !FLASH_WR)) else $error("Store passed global write lock");
    glb_rwlock_a: assert property ((accept && glb_lk == 2'h0) |=>
        (CPU_DENY && !FLASH_RD && !FLASH_WR)) else $error("Access passed global lock");
    app_wrlock_a: assert property ((accept && CPU_STORE && !tgt_boot && !app_lk[0]) |=>
        !FLASH_WR) else $error("Store reached locked application section");
    boot_wrlock_a: assert property ((accept && CPU_STORE && tgt_boot && !boot_lk[0]) |=>
        !FLASH_WR) else $error("Store reached locked boot section");
    app_rdlock_a: assert property ((accept && !CPU_STORE && exec_boot && !tgt_boot
        && !app_lk[1]) |=> (CPU_DENY && !FLASH_RD)) else $error("Boot code read locked app");
    store_origin_a: assert property ((accept && CPU_STORE && !exec_boot) |=>
        (CPU_DENY && !CPU_BUSY)) else $error("Store from application accepted");
    free_path_a: assert property ((accept && CPU_STORE && exec_boot && lock_q == 6'h3f)
        |=> (FLASH_WR && CPU_BUSY) ##1 CPU_BUSY [*3] ##1 !CPU_BUSY)
        else $error("Free store not performed");
    addr_hold_a: assert property ((CPU_BUSY && $past(CPU_BUSY)) |-> $stable(addr_q))
        else $error("Address moved during programming");
    lock_clear_a: assert property (((lock_q & ~$past(lock_q)) != 6'h00) |->
        $past(erase_s)) else $error("Lock bit cleared without erase");
    // Reset term keeps the release edge, where the vector still holds its reset value, out
    reset_vec_a: assert property ((!SYS_RST && !fuse_s) |=>
        (RESET_VECTOR == BOOT_START_WORD)) else $error("Reset vector ignores programmed fuse");
    vec_app_a: assert property (fuse_s |=>
        (RESET_VECTOR == fblp_pkg::FBLP_APP_RESET_WORD)) else $error("Reset vector not word 0");
    irq_gate_a: assert property ((!exec_boot && CPU_IVEC_BOOT && app_lk == 2'h0) |=>
        IRQ_SUPPRESS) else $error("Interrupt not suppressed");
    bus_answer_a: assert property ((bus_req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
        else $error("Bus answer late");
    wait_once_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("Wait request low for more than one cycle");
    boot_rdlock_a: assert property ((accept && !CPU_STORE && !exec_boot && tgt_boot
        && !boot_lk[1]) |=> (CPU_DENY && !FLASH_RD)) else $error("App code read locked boot");
    irq_boot_a: assert property ((exec_boot && !CPU_IVEC_BOOT && !boot_lk[1]) |=>
        IRQ_SUPPRESS) else $error("Interrupt not suppressed in boot section");
    irq_free_a: assert property ((app_lk[1] && boot_lk[1]) |=> !IRQ_SUPPRESS)
        else $error("Interrupt suppressed with read locks free");
    load_free_a: assert property ((accept && !CPU_STORE && lock_q == 6'h3f) |=>
        (FLASH_RD && !CPU_DENY)) else $error("Free load not performed");
    one_answer_a: assert property (accept |=> $onehot({FLASH_WR, FLASH_RD, CPU_DENY}))
        else $error("Accepted request without a single answer");
    busy_ignore_a: assert property ((CPU_REQ && CPU_BUSY) |=>
        !(FLASH_WR || FLASH_RD || CPU_DENY)) else $error("Request answered while busy");
    busy_start_a: assert property ($rose(CPU_BUSY) |-> FLASH_WR)
        else $error("Busy without a granted store");
    // The pointer moves right after a grant, so the latch must hold the old one
    addr_latch_a: assert property ((accept && access_ok) |=> (addr_q == $past(ptr)))
        else $error("Latched address differs from pointer");
    word_offset_a: assert property ((accept && access_ok) |=>
        (FLASH_WORD == $past(ptr[PAGE_WORD_BITS:1]))) else $error("Word offset misplaced");
    byte_select_a: assert property ((accept && !CPU_STORE && access_ok) |=>
        (FLASH_BYTE_SEL == $past(CPU_PTR_LO[0]))) else $error("Byte select not pointer bit 0");
    erase_set_a: assert property (erase_s |=> (lock_q == fblp_pkg::FBLP_LOCK_RST))
        else $error("Erase left a lock bit programmed");
    lock_write_a: assert property ((bus_done && AVS_WRITE && AVS_BYTEENABLE[0] && !erase_s
        && AVS_ADDRESS == fblp_pkg::FBLP_REG_LOCK_OFS) |=>
        (lock_q == ($past(lock_q) & $past(AVS_WRITEDATA[5:0]))))
        else $error("Lock write did not only program bits");
    ext_write_a: assert property ((HAS_EXT && bus_done && AVS_WRITE
        && AVS_BYTEENABLE[0] && AVS_ADDRESS == fblp_pkg::FBLP_REG_EXT_OFS) |=>
        (ext_q == $past(AVS_WRITEDATA[7:0]))) else $error("Extension byte write lost");
    rd_lock_a: assert property ((AVS_READ && AVS_WAITREQUEST
        && AVS_ADDRESS == fblp_pkg::FBLP_REG_LOCK_OFS) |=>
        (AVS_READDATA[5:0] == $past(lock_q))) else $error("Lock read back wrong");

    store_done_c: cover property ((FLASH_WR && CPU_BUSY) ##1 CPU_BUSY [*3] ##1 !CPU_BUSY);
    boot_store_c: cover property (accept && CPU_STORE && tgt_boot ##1 FLASH_WR);
    load_deny_c: cover property (accept && !CPU_STORE ##1 CPU_DENY);
    erase_c: cover property (lock_q != 6'h3f ##1 lock_q == 6'h3f);
    irq_sup_c: cover property ($rose(IRQ_SUPPRESS));
endmodule // fblp_core

// [testbench/fblp_cpu_model.sv]
// CPU core model issuing load-program and store-program requests
`timescale 1ns/1ns
module fblp_cpu_model (
    input wire logic clk,
    input wire logic busy,
    output logic req,
    output logic store,
    output logic [22:0] pc,
    output logic [7:0] ptr_hi,
    output logic [7:0] ptr_lo,
    output logic ivec
);
    initial begin
        req = 1'b0;
        store = 1'b0;
        pc = 23'h0;
        {ptr_hi, ptr_lo} = 16'h0;
        ivec = 1'b0;
    end
    task automatic mode(input logic [22:0] p, input logic iv);
        pc <= p;
        ivec <= iv;
    endtask
    // Pointer is the caller's, passed in unchanged for loads and stores
    task automatic access(input logic st, input logic [22:0] p, input logic [15:0] z,
                          input bit nowait);
        if (!nowait)
            while (busy === 1'b1) @(posedge clk);
        req <= 1'b1;
        store <= st;
        pc <= p;
        {ptr_hi, ptr_lo} <= z;
        @(posedge clk);
        req <= 1'b0;
        // Pointer reused at once, so a stale copy would show
        {ptr_hi, ptr_lo} <= ~z;
        // Extra edge lets busy appear before the next request
        @(posedge clk);
    endtask
endmodule // fblp_cpu_model

// [testbench/tb_top.sv]
// Self-checking bench of the flash boot-lock protection core
`timescale 1ns/1ns
module tb_top;
    localparam logic [22:0] BW = 23'h00f000;
    logic CORE_CLK = 1'b0, SYS_RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'h1;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic FUSE_BOOT_RESET = 1'b1, CHIP_ERASE = 1'b0, SER_LOCK_STROBE = 1'b0;
    logic [5:0] SER_LOCK_DATA = 6'h3f;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST, CPU_REQ, CPU_STORE, CPU_IVEC_BOOT, CPU_BUSY, CPU_DENY;
    logic [22:0] CPU_PC, RESET_VECTOR;
    logic [7:0] CPU_PTR_HI, CPU_PTR_LO;
    logic IRQ_SUPPRESS, FLASH_WR, FLASH_RD, FLASH_BYTE_SEL;
    logic [15:0] FLASH_PAGE;
    logic [6:0] FLASH_WORD;
    int mismatches = 0;
    int cmp_count = 0;
    logic [26:0] exq[$];
    logic [22:0] pa, pb;
    logic [23:0] aa, ab;
    fblp_core dut (.CORE_CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .CPU_REQ,
        .CPU_STORE, .CPU_PC, .CPU_PTR_HI, .CPU_PTR_LO, .CPU_IVEC_BOOT, .CPU_BUSY,
        .CPU_DENY, .IRQ_SUPPRESS, .RESET_VECTOR, .FUSE_BOOT_RESET, .CHIP_ERASE,
        .SER_LOCK_STROBE, .SER_LOCK_DATA, .FLASH_WR, .FLASH_RD, .FLASH_PAGE,
        .FLASH_WORD, .FLASH_BYTE_SEL);
    fblp_cpu_model cpu (.clk(CORE_CLK), .busy(CPU_BUSY), .req(CPU_REQ), .store(CPU_STORE),
        .pc(CPU_PC), .ptr_hi(CPU_PTR_HI), .ptr_lo(CPU_PTR_LO), .ivec(CPU_IVEC_BOOT));
    always #5 CORE_CLK = ~CORE_CLK;
    task automatic report(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_res(input logic [26:0] e, input logic [26:0] g);
        report({5'h0, e}, {5'h0, g});
    endtask
    task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
        report(e, g);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic avs(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        AVS_ADDRESS <= a;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_WRITEDATA <= {24'h0, d};
        @(posedge CORE_CLK);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge CORE_CLK);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        avs(1'b1, a, d, q);
    endtask
    task automatic rdm(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        avs(1'b0, a, 8'h0, q);
        cmp_val(e, q & m);
    endtask
    // Expected {write, read, deny} from executing section, target section and locks
    function automatic logic [2:0] verdict(logic st, logic [22:0] p, logic [23:0] a,
                                           logic [5:0] lk);
        logic pbt, tbt, dn;
        logic [1:0] m;
        pbt = p >= BW;
        tbt = a[23:1] >= BW;
        m = tbt ? lk[5:4] : lk[3:2];
        if (st)
            dn = !pbt || !lk[0] || !m[0];
        else
            dn = lk[1:0] == 2'h0 || (pbt != tbt && !m[1]);
        return dn ? 3'b001 : (st ? 3'b100 : 3'b010);
    endfunction
    task automatic go(input logic st, input logic [22:0] p, input logic [23:0] a,
                      input logic [5:0] lk);
        logic [2:0] k;
        k = verdict(st, p, a, lk);
        wr(4'h0, a[23:16]);
        exq.push_back({k, k[0] ? 24'h0 : a});
        cpu.access(st, p, a[15:0], 1'b0);
    endtask
    task automatic erase();
        CHIP_ERASE <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        CHIP_ERASE <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        rdm(4'h4, 32'hffffffff, 32'h3f);
    endtask
    task automatic newaddr();
        pa = 23'($urandom_range(0, 32'(BW) - 1));
        pb = BW + 23'($urandom_range(0, 32'hfff));
        aa = 24'($urandom_range(0, 32'h1dfff));
        ab = 24'h01e000 + 24'($urandom_range(0, 32'h1fff));
    endtask
    // Grants carry the latched page, word and byte select
    always @(posedge CORE_CLK) begin
        if (!SYS_RST && (FLASH_WR || FLASH_RD || CPU_DENY)) begin
            if (exq.size() == 0)
                cmp_res(27'h0, {FLASH_WR, FLASH_RD, CPU_DENY, 24'h0});
            else
                cmp_res(exq.pop_front(), {FLASH_WR, FLASH_RD, CPU_DENY, CPU_DENY ? 24'h0 :
                    {FLASH_PAGE, FLASH_WORD, FLASH_BYTE_SEL}});
        end
    end
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        logic [1:0] ma, mb;
        logic [5:0] lk;
        void'($urandom(32'hd73b094e));
        repeat (16) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        @(posedge CORE_CLK);
        for (int m = 0; m < 4; m++) begin
            erase();
            newaddr();
            ma = 2'(m);
            mb = ~ma;
            lk = {mb, ma, 2'h3};
            wr(4'h4, {2'h3, lk});
            wr(4'h4, 8'hff);
            rdm(4'h4, 32'hffffffff, {26'h0, lk});
            go(1'b1, pb, aa, lk);
            go(1'b1, pb, ab, lk);
            go(1'b0, pb, aa, lk);
            go(1'b0, pa, ab, lk);
            go(1'b0, pa, aa, lk);
            go(1'b1, pa, aa, lk);
            cpu.mode(pa, 1'b1);
            repeat (3) @(posedge CORE_CLK);
            cmp_val({31'h0, !ma[1]}, {31'h0, IRQ_SUPPRESS});
            cpu.mode(pb, 1'b0);
            repeat (3) @(posedge CORE_CLK);
            cmp_val({31'h0, !mb[1]}, {31'h0, IRQ_SUPPRESS});
        end
        for (int g = 0; g < 4; g++) begin
            erase();
            newaddr();
            wr(4'h4, {6'h3f, 2'(g)});
            go(1'b1, pb, aa, {4'hf, 2'(g)});
            go(1'b0, pb, ab, {4'hf, 2'(g)});
        end
        erase();
        newaddr();
        go(1'b1, pb, aa, 6'h3f);
        cpu.access(1'b0, pb, ab[15:0], 1'b1);
        go(1'b1, pb, aa, 6'h3f);
        rdm(4'h0, 32'hff, {24'h0, aa[23:16]});
        rdm(4'hc, 32'hffffffff, 32'h0);
        SER_LOCK_DATA <= 6'h2b;
        SER_LOCK_STROBE <= 1'b1;
        repeat (6) @(posedge CORE_CLK);
        SER_LOCK_STROBE <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        rdm(4'h4, 32'hffffffff, 32'h2b);
        FUSE_BOOT_RESET <= 1'b0;
        repeat (5) @(posedge CORE_CLK);
        cmp_val({9'h0, BW}, {9'h0, RESET_VECTOR});
        wr(4'h8, 8'hff);
        rdm(4'h8, 32'h4, 32'h0);
        FUSE_BOOT_RESET <= 1'b1;
        repeat (5) @(posedge CORE_CLK);
        cmp_val(32'h0, {9'h0, RESET_VECTOR});
        rdm(4'h8, 32'h4, 32'h4);
        cmp_val(32'h0, 32'(exq.size()));
        tally_and_finish();
    end
endmodule // tb_top
